// ---- core/fcs_pkg.sv ----
// shared constants and types of the fieldbus coupler status block
// How it works
// RULE1: network lamp dark until controller initializes the coupler, and while unpowered.
// RULE2: initialized and scanned: network lamp green, application drives all outputs.
// RULE3: initialized but link lost or scan stopped: lamp red, all outputs forced off.
// RULE4: module bus not accessed: module-bus lamp dark, all outputs forced off.
// RULE5: module bus properly accessed by the application: module-bus lamp green.
// RULE6: module bus fault: lamp red, coupler outputs live, module outputs forced off.
// RULE7: node address is tens dial times ten plus units dial.
// RULE8: valid node addresses run from one to sixty-four.
// RULE9: upstream port upper lamp yellow when onboard self-diagnostics failed.
// RULE10: upstream port lower lamp green while a device is connected there.
// RULE11: downstream port lamp green while a device is connected there.
// RULE12: one indicator lamp per integrated I/O point showing its state.
// RULE13: dials synchronized and debounced; address outside one to sixty-four means unaddressed.
package fcs_pkg;

    // ------------------------------------------------------------
    // bus and register map
    // ------------------------------------------------------------
    localparam int        AXI_ADDR_W     = 8;
    localparam int        DATA_W         = 32;
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_STATUS     = 8'h04;
    localparam logic [7:0] REG_OUTPUTS    = 8'h08;
    localparam logic [7:0] REG_INPUTS     = 8'h0C;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h10;
    localparam logic [7:0] REG_IRQ_MASK   = 8'h14;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_INIT_BIT  = 0;
    localparam int ST_NET_GREEN   = 0;
    localparam int ST_NET_RED     = 1;
    localparam int ST_MB_GREEN    = 2;
    localparam int ST_MB_RED      = 3;
    localparam int ST_DIAG        = 4;
    localparam int ST_IN_LINK     = 5;
    localparam int ST_OUT_LINK    = 6;
    localparam int ST_SCANNING    = 7;
    localparam int ST_ADDR_LSB    = 8;
    localparam int ST_ADDR_VALID  = 15;
    localparam int IRQ_LINK_LOST  = 0;
    localparam int IRQ_MBUS_FAULT = 1;
    localparam int IRQ_DIAG_FAIL  = 2;
    localparam int IRQ_ADDR_BAD   = 3;
    localparam int IRQ_W          = 4;

    // ------------------------------------------------------------
    // points, address and timing
    // ------------------------------------------------------------
    localparam int          NUM_IN      = 16;
    localparam int          NUM_OUT     = 16;
    localparam int          DIAL_W      = 4;
    localparam int          ADDR_W      = 7;
    localparam logic [3:0]  DIGIT_MAX   = 4'h9;
    localparam logic [7:0]  TENS_WEIGHT = 8'h0A;
    localparam logic [7:0]  ADDR_MIN    = 8'h01;
    localparam logic [7:0]  ADDR_MAX    = 8'h40;
    localparam int          CLK_MHZ     = 100;
    localparam int          DEBOUNCE_MS = 10;
    localparam int          SCAN_TO_MS  = 50;
    localparam int          DEBOUNCE_CYCLES = DEBOUNCE_MS * CLK_MHZ * 1000;
    localparam int          SCAN_CYCLES     = SCAN_TO_MS * CLK_MHZ * 1000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FCS_NET_OFF  = 3'b001,
        FCS_NET_RUN  = 3'b010,
        FCS_NET_LOST = 3'b100
    } fcs_net_t;

    typedef struct packed {
        logic red;
        logic green;
    } fcs_lamp_t;

    typedef struct packed {
        fcs_net_t                   ns;
        logic                       init;
        logic                       scanning;
        logic [31:0]                scan_cnt;
        logic [NUM_OUT-1:0]         out_reg;
        logic [NUM_IN-1:0]          in_reg;
        logic [IRQ_W-1:0]           irq_st;
        logic [IRQ_W-1:0]           mask;
        logic                       irq;
        logic                       awready;
        logic                       bvalid;
        logic [1:0]                 bresp;
        logic                       arready;
        logic                       rvalid;
        logic [1:0]                 rresp;
        logic [DATA_W-1:0]          rdata;
        fcs_lamp_t                  net_lamp;
        fcs_lamp_t                  mb_lamp;
        logic                       diag;
        logic                       in_link;
        logic                       out_link;
        logic [NUM_OUT-1:0]         cpl_out;
        logic                       mod_en;
        logic [NUM_IN+NUM_OUT-1:0]  points;
        logic [ADDR_W-1:0]          node_addr;
        logic                       addr_valid;
        logic                       addr_bad;
    } fcs_state_t;

endpackage

// ---- core/fcs_dial_filter.sv ----
// synchroniser and debouncer for the address dials
`timescale 1ns/1ps
`default_nettype none
module fcs_dial_filter #(
    parameter int W      = 8,
    parameter int CYCLES = 1000000
) (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // raw dial lines
    input  wire logic [W-1:0] raw,
    // filtered value
    output logic      [W-1:0] stable,
    output logic              settled
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] cand;
        logic [31:0]  cnt;
        logic [W-1:0] val;
        logic         ok;
    } fcs_filt_t;

    fcs_filt_t q;
    fcs_filt_t d;

    // s1 feeds only s2, as any synchroniser first stage must
    always_comb begin
        d    = q;
        d.s1 = raw;
        d.s2 = q.s1;
        if (q.s2 != q.cand) begin
            d.cand = q.s2;
            d.cnt  = '0;
        end else if (q.cnt == 32'(CYCLES - 1)) begin
            d.val = q.cand;
            d.ok  = 1'b1;
        end else begin
            d.cnt = q.cnt + 32'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign stable  = q.val;
    assign settled = q.ok;

endmodule // fcs_dial_filter
`default_nettype wire

// ---- core/fcs_top.sv ----
// coupler status lamps, output forcing, node address and register slave
`timescale 1ns/1ps
`default_nettype none
module fcs_top
    import fcs_pkg::*;
#(
    parameter int DEBOUNCE_CYC = fcs_pkg::DEBOUNCE_CYCLES,
    parameter int SCAN_CYC     = fcs_pkg::SCAN_CYCLES
) (
    // clock and reset
    input  wire logic                           aclk,
    input  wire logic                           aresetn,
    // axi4-lite write
    input  wire logic [fcs_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                           s_axi_awvalid,
    output logic                                s_axi_awready,
    input  wire logic [fcs_pkg::DATA_W-1:0]     s_axi_wdata,
    input  wire logic [3:0]                     s_axi_wstrb,
    input  wire logic                           s_axi_wvalid,
    output logic                                s_axi_wready,
    output logic [1:0]                          s_axi_bresp,
    output logic                                s_axi_bvalid,
    input  wire logic                           s_axi_bready,
    // axi4-lite read
    input  wire logic [fcs_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                           s_axi_arvalid,
    output logic                                s_axi_arready,
    output logic [fcs_pkg::DATA_W-1:0]          s_axi_rdata,
    output logic [1:0]                          s_axi_rresp,
    output logic                                s_axi_rvalid,
    input  wire logic                           s_axi_rready,
    // network and module-bus health
    input  wire logic                           net_link_ok,
    input  wire logic                           mbus_access,
    input  wire logic                           mbus_fault,
    input  wire logic                           selftest_fail,
    input  wire logic                           in_port_link,
    input  wire logic                           out_port_link,
    // address dials
    input  wire logic [fcs_pkg::DIAL_W-1:0]     tens_address_dial,
    input  wire logic [fcs_pkg::DIAL_W-1:0]     units_address_dial,
    // integrated i/o points
    input  wire logic [fcs_pkg::NUM_IN-1:0]     fast_in,
    output logic [fcs_pkg::NUM_OUT-1:0]         fast_out,
    output logic                                module_out_enable,
    // lamps
    output fcs_pkg::fcs_lamp_t                  network_status_lamp,
    output fcs_pkg::fcs_lamp_t                  module_bus_status_lamp,
    output logic                                in_diag_lamp_yellow,
    output logic                                in_link_lamp_green,
    output logic                                out_link_lamp_green,
    output logic [fcs_pkg::NUM_IN+fcs_pkg::NUM_OUT-1:0] point_lamps,
    // node address and interrupt
    output logic [fcs_pkg::ADDR_W-1:0]          node_addr,
    output logic                                node_addr_valid,
    output logic                                irq
);
    import fcs_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [DATA_W-1:0] strb_mask(input logic [3:0] s);
        logic [DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{s[i]}};
        end
        return m;
    endfunction

    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                                input logic [DATA_W-1:0] nw,
                                                input logic [3:0]        s);
        return (old & ~strb_mask(s)) | (nw & strb_mask(s));
    endfunction

    function automatic logic mapped(input logic [AXI_ADDR_W-1:0] a);
        return a == REG_CTRL || a == REG_STATUS || a == REG_OUTPUTS ||
               a == REG_INPUTS || a == REG_IRQ_STATUS || a == REG_IRQ_MASK;
    endfunction

    // ------------------------------------------------------------
    // dial filter
    // ------------------------------------------------------------
    logic [2*DIAL_W-1:0] dials;
    logic                dials_ok;

    fcs_dial_filter #(
        .W      (2 * DIAL_W),
        .CYCLES (DEBOUNCE_CYC)
    ) u_dials (
        .aclk    (aclk),
        .aresetn (aresetn),
        .raw     ({tens_address_dial, units_address_dial}),
        .stable  (dials),
        .settled (dials_ok)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    fcs_state_t q;
    fcs_state_t d;

    logic                  wr;
    logic                  rd;
    logic [DATA_W-1:0]     status_w;
    logic [DATA_W-1:0]     rmux;
    logic [DATA_W-1:0]     wval;
    logic [IRQ_W-1:0]      ev;
    logic [7:0]            calc;
    logic                  ok_run;
    logic                  addr_ok;

    always_comb begin
        d        = q;
        ev       = '0;
        wr       = q.awready && s_axi_awvalid && s_axi_wvalid;
        rd       = q.arready && s_axi_arvalid;
        wval     = '0;
        status_w = '0;
        status_w[ST_NET_GREEN]  = q.net_lamp.green;
        status_w[ST_NET_RED]    = q.net_lamp.red;
        status_w[ST_MB_GREEN]   = q.mb_lamp.green;
        status_w[ST_MB_RED]     = q.mb_lamp.red;
        status_w[ST_DIAG]       = q.diag;
        status_w[ST_IN_LINK]    = q.in_link;
        status_w[ST_OUT_LINK]   = q.out_link;
        status_w[ST_SCANNING]   = q.scanning;
        status_w[ST_ADDR_LSB +: ADDR_W] = q.node_addr;
        status_w[ST_ADDR_VALID] = q.addr_valid;

        // write channel: both halves taken on one edge
        d.awready = !q.awready && !q.bvalid && s_axi_awvalid && s_axi_wvalid;
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (wr) begin
            d.bvalid = 1'b1;
            d.bresp  = mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_awaddr)
                REG_CTRL: begin
                    wval   = merge(DATA_W'(q.init), s_axi_wdata, s_axi_wstrb);
                    d.init = wval[CTRL_INIT_BIT];
                end
                REG_OUTPUTS: begin
                    wval      = merge(DATA_W'(q.out_reg), s_axi_wdata, s_axi_wstrb);
                    d.out_reg = wval[NUM_OUT-1:0];
                end
                REG_IRQ_MASK: begin
                    wval   = merge(DATA_W'(q.mask), s_axi_wdata, s_axi_wstrb);
                    d.mask = wval[IRQ_W-1:0];
                end
                REG_IRQ_STATUS: begin
                    wval     = s_axi_wdata & strb_mask(s_axi_wstrb);
                    d.irq_st = q.irq_st & ~wval[IRQ_W-1:0];
                end
                default: begin
                    wval = '0;
                end
            endcase
        end

        // read channel
        case (s_axi_araddr)
            REG_CTRL:       rmux = DATA_W'(q.init);
            REG_STATUS:     rmux = status_w;
            REG_OUTPUTS:    rmux = DATA_W'(q.out_reg);
            REG_INPUTS:     rmux = DATA_W'(q.in_reg);
            REG_IRQ_STATUS: rmux = DATA_W'(q.irq_st);
            REG_IRQ_MASK:   rmux = DATA_W'(q.mask);
            default:        rmux = '0;
        endcase
        d.arready = !q.arready && !q.rvalid && s_axi_arvalid;
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (rd) begin
            d.rvalid = 1'b1;
            d.rdata  = rmux;
            d.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end

        // scan watchdog: each output write counts as one application scan
        if (wr && s_axi_awaddr == REG_OUTPUTS) begin
            d.scanning = 1'b1;
            d.scan_cnt = '0;
        end else if (q.scan_cnt == 32'(SCAN_CYC - 1)) begin
            d.scanning = 1'b0;
        end else if (q.scanning) begin
            d.scan_cnt = q.scan_cnt + 32'h1;
        end

        // network state
        ok_run = net_link_ok && q.scanning;
        case (q.ns)
            FCS_NET_OFF: begin
                if (q.init) begin
                    d.ns = ok_run ? FCS_NET_RUN : FCS_NET_LOST; // RULE2 RULE3
                end
            end
            FCS_NET_RUN: begin
                if (!q.init) begin
                    d.ns = FCS_NET_OFF; // RULE1
                end else if (!ok_run) begin
                    d.ns = FCS_NET_LOST; // RULE3
                end
            end
            FCS_NET_LOST: begin
                if (!q.init) begin
                    d.ns = FCS_NET_OFF; // RULE1
                end else if (ok_run) begin
                    d.ns = FCS_NET_RUN; // RULE2
                end
            end
            default: begin
                d.ns = FCS_NET_OFF;
            end
        endcase
        d.net_lamp.green = d.ns == FCS_NET_RUN;  // RULE1 RULE2
        d.net_lamp.red   = d.ns == FCS_NET_LOST; // RULE1 RULE3

        // module bus lamp and output forcing
        d.mb_lamp.red   = mbus_fault;                 // RULE6
        d.mb_lamp.green = !mbus_fault && mbus_access; // RULE4 RULE5
        d.cpl_out = (d.ns == FCS_NET_RUN && (mbus_access || mbus_fault)) ?
                    d.out_reg : '0; // RULE2 RULE3 RULE4 RULE6
        d.mod_en  = d.ns == FCS_NET_RUN && mbus_access && !mbus_fault; // RULE3 RULE4 RULE6

        // port lamps and point lamps
        d.diag     = selftest_fail; // RULE9
        d.in_link  = in_port_link;  // RULE10
        d.out_link = out_port_link; // RULE11
        d.in_reg   = fast_in;
        d.points   = {d.cpl_out, fast_in}; // RULE12

        // node address
        calc    = 8'(dials[2*DIAL_W-1:DIAL_W]) * TENS_WEIGHT
                + 8'(dials[DIAL_W-1:0]); // RULE7
        addr_ok = dials_ok && dials[2*DIAL_W-1:DIAL_W] <= DIGIT_MAX &&
                  dials[DIAL_W-1:0] <= DIGIT_MAX &&
                  calc >= ADDR_MIN && calc <= ADDR_MAX; // RULE8 RULE13
        d.addr_valid = addr_ok;
        d.node_addr  = addr_ok ? calc[ADDR_W-1:0] : '0; // RULE13
        d.addr_bad   = dials_ok && !addr_ok;

        // sticky events; a set in the clearing cycle wins
        ev[IRQ_LINK_LOST]  = d.ns == FCS_NET_LOST && q.ns != FCS_NET_LOST;
        ev[IRQ_MBUS_FAULT] = mbus_fault && !q.mb_lamp.red;
        ev[IRQ_DIAG_FAIL]  = selftest_fail && !q.diag;
        ev[IRQ_ADDR_BAD]   = d.addr_bad && !q.addr_bad;
        d.irq_st = d.irq_st | ev;
        d.irq    = |(d.irq_st & d.mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q    <= '0;
            q.ns <= FCS_NET_OFF; // RULE1
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready          = q.awready;
    assign s_axi_wready           = q.awready;
    assign s_axi_bvalid           = q.bvalid;
    assign s_axi_bresp            = q.bresp;
    assign s_axi_arready          = q.arready;
    assign s_axi_rvalid           = q.rvalid;
    assign s_axi_rdata            = q.rdata;
    assign s_axi_rresp            = q.rresp;
    assign fast_out               = q.cpl_out;
    assign module_out_enable      = q.mod_en;
    assign network_status_lamp    = q.net_lamp;
    assign module_bus_status_lamp = q.mb_lamp;
    assign in_diag_lamp_yellow    = q.diag;
    assign in_link_lamp_green     = q.in_link;
    assign out_link_lamp_green    = q.out_link;
    assign point_lamps            = q.points;
    assign node_addr              = q.node_addr;
    assign node_addr_valid        = q.addr_valid;
    assign irq                    = q.irq;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_net_dark_off: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
        q.ns == FCS_NET_OFF |-> !q.net_lamp.green && !q.net_lamp.red && q.cpl_out == '0)
        else $error("network lamp lit before init");
    a_net_green_run: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
        q.init && q.ns == FCS_NET_RUN && net_link_ok && q.scanning && mbus_access
        |=> q.net_lamp.green && fast_out == q.out_reg)
        else $error("scanned outputs not driven");
    a_lost_forced_off: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
        q.init && !net_link_ok |=> q.net_lamp.red && fast_out == '0 && !module_out_enable)
        else $error("link loss did not force outputs off");
    a_mbus_idle_off: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
        !mbus_access && !mbus_fault
        |=> !q.mb_lamp.green && !q.mb_lamp.red && fast_out == '0 && !module_out_enable)
        else $error("idle module bus not forced off");
    a_mbus_green_on: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
        mbus_access && !mbus_fault |=> q.mb_lamp.green && !q.mb_lamp.red)
        else $error("module bus lamp not green");
    a_mbus_fault_red: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
        mbus_fault && q.ns == FCS_NET_RUN && q.init && net_link_ok && q.scanning
        |=> q.mb_lamp.red && !module_out_enable && fast_out == q.out_reg)
        else $error("module bus fault handling wrong");
    a_addr_sum_ok: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
        q.addr_valid |-> 8'(q.node_addr) ==
        8'($past(dials[7:4])) * TENS_WEIGHT + 8'($past(dials[3:0])))
        else $error("node address not tens times ten plus units");
    a_addr_in_range: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
        q.addr_valid |-> q.node_addr >= 7'h01 && q.node_addr <= 7'h40)
        else $error("node address out of range");
    a_addr_bad_zero: assert property (@(posedge aclk) disable iff (!aresetn) // RULE13
        !q.addr_valid |-> q.node_addr == '0)
        else $error("invalid address not cleared");
    a_diag_lamp_on: assert property (@(posedge aclk) disable iff (!aresetn) // RULE9
        selftest_fail |=> in_diag_lamp_yellow)
        else $error("diagnostic lamp not lit");
    a_in_link_lamp: assert property (@(posedge aclk) disable iff (!aresetn) // RULE10
        aresetn |=> in_link_lamp_green == $past(in_port_link))
        else $error("upstream link lamp wrong");
    a_out_link_lamp: assert property (@(posedge aclk) disable iff (!aresetn) // RULE11
        aresetn |=> out_link_lamp_green == $past(out_port_link))
        else $error("downstream link lamp wrong");
    a_point_lamp_map: assert property (@(posedge aclk) disable iff (!aresetn) // RULE12
        aresetn |=> point_lamps == {fast_out, $past(fast_in)})
        else $error("point lamps do not follow points");

endmodule // fcs_top
`default_nettype wire

// ---- tb/fcs_net_model.sv ----
// partner model: controller link, module bus and port health levels
`timescale 1ns/1ps
`default_nettype none
module fcs_net_model (
    // clock
    input  wire logic       aclk,
    // scenario selection from the bench
    input  wire logic [5:0] mode,
    // health levels seen by the coupler
    output logic            net_link_ok,
    output logic            mbus_access,
    output logic            mbus_fault,
    output logic            selftest_fail,
    output logic            in_port_link,
    output logic            out_port_link
);
    // registered so every level changes just after an edge, like real logic
    always_ff @(posedge aclk) begin
        {out_port_link, in_port_link, selftest_fail} <= mode[5:3];
        {mbus_fault, mbus_access, net_link_ok} <= mode[2:0];
    end
endmodule // fcs_net_model
`default_nettype wire

// ---- tb/tb_fcs_top.sv ----
// self-checking bench of the coupler status block
`timescale 1ns/1ps
`default_nettype none
module tb_fcs_top;
    import fcs_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rv, rdata, pl;
    logic [1:0] resp, bresp, rresp;
    logic [3:0] tens = '0, units = '0;
    logic [5:0] mode = '0;
    logic [15:0] fout;
    logic [6:0] na;
    logic awready, wready, arready, bvalid, rvalid, moe, irq, nav, dy, il, ol;
    logic nlo, mac, mft, stf, ipl, opl;
    fcs_lamp_t nl, ml;
    int fail_count = 0, checks = 0;
    initial forever #5 aclk = ~aclk;
    fcs_net_model i_far (.aclk(aclk), .mode(mode), .net_link_ok(nlo), .mbus_access(mac),
        .mbus_fault(mft), .selftest_fail(stf), .in_port_link(ipl), .out_port_link(opl));
    fcs_top #(.DEBOUNCE_CYC(8), .SCAN_CYC(20)) i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .net_link_ok(nlo), .mbus_access(mac), .mbus_fault(mft), .selftest_fail(stf),
        .in_port_link(ipl), .out_port_link(opl), .tens_address_dial(tens),
        .units_address_dial(units), .fast_in(16'h3C5A), .fast_out(fout), .module_out_enable(moe),
        .network_status_lamp(nl), .module_bus_status_lamp(ml), .in_diag_lamp_yellow(dy),
        .in_link_lamp_green(il), .out_link_lamp_green(ol), .point_lamps(pl), .node_addr(na),
        .node_addr_valid(nav), .irq(irq));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] g, e);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    task automatic mo(input logic [5:0] m);
        @(posedge aclk);
        mode <= m;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        do @(posedge aclk); while (awready !== 1'b1);
        {awvalid, wvalid} <= 2'h0;
        do @(posedge aclk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'h0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        {rv, resp} = {rdata, rresp};
        rready <= 1'h0;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_run;
        mo(6'h03);
        wr(REG_OUTPUTS, 32'hA5C3);
        cyc(3);
        chk(nl, 2'h0);
        chk(fout, 16'h0);
        wr(REG_CTRL, 32'h1);
        wr(REG_OUTPUTS, 32'hA5C3);
        cyc(2);
        chk(nl, 2'h1);
        chk({moe, ml, fout}, 19'h5A5C3);
        chk(pl, 32'hA5C33C5A);
        mo(6'h07);
        wr(REG_OUTPUTS, 32'h00FF);
        cyc(3);
        chk({moe, ml, fout}, 19'h200FF);
        mo(6'h01);
        wr(REG_OUTPUTS, 32'h00FF);
        cyc(3);
        chk({moe, ml, fout}, 19'h0);
        $display("t_run done");
    endtask
    task automatic t_lost;
        mo(6'h03);
        wr(REG_OUTPUTS, 32'hFFFF);
        cyc(24);
        chk({nl, moe, fout}, 19'h40000);
        chk(irq, 1'h0);
        wr(REG_IRQ_MASK, 32'h1);
        cyc(2);
        chk(irq, 1'h1);
        wr(REG_IRQ_STATUS, 32'h1);
        cyc(2);
        chk(irq, 1'h0);
        wr(REG_OUTPUTS, 32'h1);
        mo(6'h02);
        cyc(3);
        chk({nl, fout}, 18'h20000);
        $display("t_lost done");
    endtask
    task automatic t_port;
        mo(6'h38);
        cyc(3);
        chk({dy, il, ol}, 3'h7);
        rd(REG_STATUS);
        chk(rv[6:4], 3'h7);
        mo(6'h00);
        cyc(3);
        chk({dy, il, ol}, 3'h0);
        $display("t_port done");
    endtask
    task automatic t_addr;
        logic [7:0] tab [6] = '{8'h25, 8'h64, 8'h65, 8'h00, 8'h01, 8'h1A};
        logic [7:0] a;
        logic ok;
        for (int i = 0; i < 6; i++) begin
            @(posedge aclk);
            {tens, units} <= tab[i];
            cyc(20);
            a = tab[i][7:4] * TENS_WEIGHT + tab[i][3:0];
            ok = tab[i][3:0] <= DIGIT_MAX && a >= ADDR_MIN && a <= ADDR_MAX;
            chk({nav, na}, {ok, ok ? a[6:0] : 7'h0});
        end
        $display("t_addr done");
    endtask
    task automatic t_bus;
        wr(8'h20, 32'h1);
        chk(resp, RESP_SLVERR);
        rd(8'h20);
        chk(rv, 32'h0);
        chk(resp, RESP_SLVERR);
        rd(REG_INPUTS);
        chk(rv, 32'h3C5A);
        wr(REG_CTRL, 32'h0);
        chk(resp, RESP_OKAY);
        cyc(2);
        chk(nl, 2'h0);
        $display("t_bus done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge aclk);
        fail_count++;
        close_out;
    end
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        cyc(1);
        chk(nl, 2'h0);
        t_run;
        t_lost;
        t_port;
        t_addr;
        t_bus;
        close_out;
    end
endmodule // tb_fcs_top
`default_nettype wire
